/* common/sag_pkg.sv */
// shared constants and types for the stack and address generation block
package sag_pkg;
    localparam int DATA_W = 16;
    localparam int REG_SEL_W = 4;
    localparam int NUM_WREGS = 16;
    localparam logic [3:0] SP_INDEX = 4'hF;
    localparam logic [3:0] WREG0_INDEX = 4'h0;
    localparam logic [15:0] STACK_FLOOR = 16'h0800;
    localparam logic [15:0] WORD_STEP = 16'h0002;
    localparam logic [15:0] BYTE_STEP = 16'h0001;
    localparam int NEAR_ADDR_W = 13;
    localparam int LIT_SHORT_W = 5;
    localparam int LIT_LONG_W = 10;
    localparam int PC_HI_W = 7;
    localparam int STATUS_LOW_W = 8;

    // addressing modes, gray-coded in the usual order of the table
    typedef enum logic [3:0] {
        SAG_MODE_FILE_DIRECT = 4'h0,
        SAG_MODE_REG_DIRECT = 4'h1,
        SAG_MODE_INDIRECT = 4'h3,
        SAG_MODE_POST_MOD = 4'h2,
        SAG_MODE_PRE_MOD = 4'h6,
        SAG_MODE_INDEXED = 4'h7,
        SAG_MODE_LIT_OFFSET = 4'h5,
        SAG_MODE_LITERAL = 4'h4,
        SAG_MODE_STACK_PUSH = 4'hC,
        SAG_MODE_STACK_POP = 4'hD
    } sag_mode_type;

    // what a push carries
    typedef enum logic [1:0] {
        SAG_PUSH_DATA = 2'h0,
        SAG_PUSH_CALL_PC = 2'h1,
        SAG_PUSH_EXC_PC = 2'h3
    } sag_push_type;

    // code segment currently executing
    typedef enum logic [1:0] {
        SAG_SEG_GENERAL = 2'h0,
        SAG_SEG_BOOT = 2'h1,
        SAG_SEG_SECURE = 2'h3
    } sag_seg_type;
endpackage : sag_pkg

/* src/sag_core.sv */
// effective address generation, stack pointer and secure ram guard
`timescale 1ns/1ps

module sag_core
    import sag_pkg::*;
#(
    parameter int ADDR_W = 16,
    parameter logic [15:0] BOOT_RAM_LO = 16'h0800,
    parameter logic [15:0] BOOT_RAM_HI = 16'h081F,
    parameter logic [15:0] SEG_RAM_LO = 16'h0820,
    parameter logic [15:0] SEG_RAM_HI = 16'h083F
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic req_i,
    input wire sag_mode_type mode_i,
    input wire logic move_instruction_i,
    input wire logic multiply_instruction_i,
    input wire logic byte_op_i,
    input wire logic step_down_i,
    input wire logic [3:0] pointer_register_i,
    input wire logic [3:0] base_operand_register_i,
    input wire logic [15:0] file_addr_i,
    input wire logic [9:0] literal_i,
    input wire logic long_literal_i,
    input wire logic [15:0] lit_offset_i,
    input wire logic wr_en_i,
    input wire logic [3:0] wr_sel_i,
    input wire logic [15:0] wr_data_i,
    input wire logic limit_wr_i,
    input wire logic [15:0] limit_data_i,
    input wire sag_push_type push_kind_i,
    input wire logic [15:0] push_data_i,
    input wire logic [6:0] pc_hi_i,
    input wire logic [7:0] status_low_byte_i,
    input wire logic boot_ram_en_i,
    input wire logic seg_ram_en_i,
    input wire sag_seg_type code_seg_i,
    input wire logic dest_to_file_i,
    output logic [15:0] ea_o,
    output logic mem_valid_o,
    output logic mem_write_o,
    output logic [15:0] mem_wdata_o,
    output logic [15:0] operand_o,
    output logic operand_is_reg_o,
    output logic [15:0] base_operand_o,
    output logic [3:0] dest_reg_o,
    output logic dest_is_file_o,
    output logic [15:0] stack_pointer_register_o,
    output logic stack_trap_o,
    output logic secure_fault_o
);
    // parameter sanity, refused while elaborating rather than at run time
    if (ADDR_W != DATA_W) begin : g_bad_width
        $error("sag_core: ADDR_W must equal 16");
    end
    if (BOOT_RAM_LO > BOOT_RAM_HI || SEG_RAM_LO > SEG_RAM_HI) begin : g_bad_win
        $error("sag_core: secure ram bounds reversed");
    end

    logic [15:0] default_working_register_reg [NUM_WREGS];
    logic [15:0] default_working_register_next [NUM_WREGS];
    logic [15:0] limit_reg;
    logic [15:0] limit_next;
    logic [15:0] ea_reg, ea_next;
    logic mem_valid_reg, mem_valid_next;
    logic mem_write_reg, mem_write_next;
    logic [15:0] mem_wdata_reg, mem_wdata_next;
    logic [15:0] operand_reg, operand_next;
    logic operand_is_reg_reg, operand_is_reg_next;
    logic [15:0] base_reg, base_next;
    logic [3:0] dest_reg_reg, dest_reg_next;
    logic dest_file_reg, dest_file_next;
    logic trap_reg, trap_next;
    logic sec_reg, sec_next;

    // true when an address falls in a protected window the segment may not use
    function automatic logic sec_denied(input logic [15:0] a,
                                        input sag_seg_type seg,
                                        input logic boot_en,
                                        input logic seg_en);
        logic in_boot;
        logic in_seg;
        in_boot = (a >= BOOT_RAM_LO) && (a <= BOOT_RAM_HI);
        in_seg = (a >= SEG_RAM_LO) && (a <= SEG_RAM_HI);
        sec_denied = (boot_en && in_boot && seg != SAG_SEG_BOOT) ||
                     (seg_en && in_seg && seg != SAG_SEG_SECURE);
    endfunction : sec_denied

    // stack-pointer address check: underflow floor and limit overrun
    function automatic logic sp_bad(input logic [15:0] a,
                                    input logic [15:0] lim,
                                    input logic is_push);
        sp_bad = (a < STACK_FLOOR) || (is_push && (a > lim));
    endfunction : sp_bad

    // address, pointer update and stack sequencing for one request
    always_comb begin
        logic [15:0] ptr;
        logic [15:0] step;
        logic [15:0] sp;
        logic [15:0] lit;
        logic [15:0] ea;
        logic uses_sp;
        logic is_push;
        logic fault;
        ptr = default_working_register_reg[pointer_register_i];
        step = byte_op_i ? BYTE_STEP : WORD_STEP;
        sp = default_working_register_reg[SP_INDEX];
        lit = long_literal_i ? {6'h00, literal_i}
                             : {11'h000, literal_i[LIT_SHORT_W-1:0]};
        ea = 16'h0000;
        uses_sp = 1'b0;
        is_push = 1'b0;
        fault = 1'b0;
        default_working_register_next = default_working_register_reg;
        limit_next = limit_reg;
        ea_next = ea_reg;
        mem_valid_next = 1'b0;
        mem_write_next = 1'b0;
        mem_wdata_next = mem_wdata_reg;
        operand_next = operand_reg;
        operand_is_reg_next = operand_is_reg_reg;
        base_next = base_reg;
        dest_reg_next = dest_reg_reg;
        dest_file_next = dest_file_reg;
        trap_next = 1'b0;
        sec_next = 1'b0;
        if (limit_wr_i) begin
            limit_next = {limit_data_i[15:1], 1'b0};
        end
        if (wr_en_i) begin
            default_working_register_next[wr_sel_i] = wr_data_i;
        end
        if (req_i) begin
            base_next = default_working_register_reg[base_operand_register_i];
            operand_is_reg_next = 1'b0;
            case (mode_i)
                SAG_MODE_FILE_DIRECT: begin
                    // move reaches everything; others only near space
                    ea = move_instruction_i ? file_addr_i
                       : {3'b000, file_addr_i[NEAR_ADDR_W-1:0]};
                    dest_file_next = dest_to_file_i;
                    dest_reg_next = multiply_instruction_i ?
                        pointer_register_i : WREG0_INDEX;
                    mem_valid_next = 1'b1;
                end
                SAG_MODE_REG_DIRECT: begin
                    operand_next = ptr;
                    operand_is_reg_next = 1'b1;
                end
                SAG_MODE_INDIRECT: begin
                    ea = ptr;
                    mem_valid_next = 1'b1;
                end
                SAG_MODE_POST_MOD: begin
                    ea = ptr;
                    default_working_register_next[pointer_register_i] =
                        step_down_i ? ptr - step : ptr + step;
                    mem_valid_next = 1'b1;
                end
                SAG_MODE_PRE_MOD: begin
                    ea = step_down_i ? ptr - step : ptr + step;
                    default_working_register_next[pointer_register_i] = ea;
                    mem_valid_next = 1'b1;
                end
                SAG_MODE_INDEXED: begin
                    ea = ptr + default_working_register_reg[base_operand_register_i];
                    mem_valid_next = 1'b1;
                end
                SAG_MODE_LIT_OFFSET: begin
                    ea = ptr + lit_offset_i;
                    mem_valid_next = 1'b1;
                end
                SAG_MODE_LITERAL: begin
                    operand_next = lit;
                    operand_is_reg_next = 1'b1;
                end
                SAG_MODE_STACK_PUSH: begin
                    ea = sp;
                    is_push = 1'b1;
                    uses_sp = 1'b1;
                    mem_valid_next = 1'b1;
                    mem_write_next = 1'b1;
                    case (push_kind_i)
                        SAG_PUSH_CALL_PC:
                            mem_wdata_next = {9'h000, pc_hi_i};
                        SAG_PUSH_EXC_PC:
                            mem_wdata_next =
                                {status_low_byte_i, 1'b0, pc_hi_i};
                        default: mem_wdata_next = push_data_i;
                    endcase
                    default_working_register_next[SP_INDEX] = sp + WORD_STEP;
                end
                SAG_MODE_STACK_POP: begin
                    ea = sp - WORD_STEP;
                    uses_sp = 1'b1;
                    mem_valid_next = 1'b1;
                    default_working_register_next[SP_INDEX] = ea;
                end
                default: begin
                    ea = ea_reg;
                end
            endcase
            // any indirect form through register fifteen is checked too
            if (pointer_register_i == SP_INDEX &&
                mode_i != SAG_MODE_REG_DIRECT &&
                mode_i != SAG_MODE_LITERAL &&
                mode_i != SAG_MODE_FILE_DIRECT) begin
                uses_sp = 1'b1;
            end
            if (uses_sp) begin
                fault = sp_bad(ea, limit_reg, is_push);
            end
            sec_next = mem_valid_next &&
                sec_denied(ea, code_seg_i, boot_ram_en_i, seg_ram_en_i);
            if (fault || sec_next) begin
                // faulting access suppressed, pointers left as they were
                mem_valid_next = 1'b0;
                mem_write_next = 1'b0;
                default_working_register_next = default_working_register_reg;
                if (wr_en_i) begin
                    default_working_register_next[wr_sel_i] = wr_data_i;
                end
            end
            trap_next = fault;
            ea_next = ea;
        end
    end

    // register stage; limit has no reset value by design
    always_ff @(posedge clk_i) begin
        limit_reg <= limit_next;
        if (rst_i) begin
            for (int i = 0; i < NUM_WREGS; i++) begin
                default_working_register_reg[i] <= 16'h0000;
            end
            ea_reg <= 16'h0000;
            mem_valid_reg <= 1'b0;
            mem_write_reg <= 1'b0;
            mem_wdata_reg <= 16'h0000;
            operand_reg <= 16'h0000;
            operand_is_reg_reg <= 1'b0;
            base_reg <= 16'h0000;
            dest_reg_reg <= 4'h0;
            dest_file_reg <= 1'b0;
            trap_reg <= 1'b0;
            sec_reg <= 1'b0;
        end else begin
            default_working_register_reg <= default_working_register_next;
            ea_reg <= ea_next;
            mem_valid_reg <= mem_valid_next;
            mem_write_reg <= mem_write_next;
            mem_wdata_reg <= mem_wdata_next;
            operand_reg <= operand_next;
            operand_is_reg_reg <= operand_is_reg_next;
            base_reg <= base_next;
            dest_reg_reg <= dest_reg_next;
            dest_file_reg <= dest_file_next;
            trap_reg <= trap_next;
            sec_reg <= sec_next;
        end
    end

    // every output comes straight from a flip-flop
    assign ea_o = ea_reg;
    assign mem_valid_o = mem_valid_reg;
    assign mem_write_o = mem_write_reg;
    assign mem_wdata_o = mem_wdata_reg;
    assign operand_o = operand_reg;
    assign operand_is_reg_o = operand_is_reg_reg;
    assign base_operand_o = base_reg;
    assign dest_reg_o = dest_reg_reg;
    assign dest_is_file_o = dest_file_reg;
    assign stack_pointer_register_o = default_working_register_reg[SP_INDEX];
    assign stack_trap_o = trap_reg;
    assign secure_fault_o = sec_reg;
endmodule : sag_core

/* verification/sag_core_monitor.sv */
// port-level checker for the stack and address generation core
`timescale 1ns/1ps
module sag_core_monitor
    import sag_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic req_i,
    input wire sag_mode_type mode_i,
    input wire logic [3:0] pointer_register_i,
    input wire logic [15:0] ea_o,
    input wire logic mem_valid_o,
    input wire logic mem_write_o,
    input wire logic [15:0] stack_pointer_register_o,
    input wire logic stack_trap_o,
    input wire logic secure_fault_o
);
    default clocking mcb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    logic push, pop;
    logic [15:0] sp;
    // request decode; a trapped request is judged by the trap alone
    assign push = req_i && mode_i == SAG_MODE_STACK_PUSH;
    assign pop = req_i && mode_i == SAG_MODE_STACK_POP;
    assign sp = stack_pointer_register_o;
    chk_push_order: assert property (
        push |=> stack_trap_o || (mem_write_o && ea_o == $past(sp)
        && sp == $past(sp) + 16'h0002)) else $error("bad push");
    chk_pop_order: assert property (
        pop |=> stack_trap_o || (mem_valid_o && !mem_write_o
        && ea_o == $past(sp) - 16'h0002 && sp == ea_o)) else $error("bad pop");
    chk_write_cause: assert property (
        mem_write_o |-> $past(push)) else $error("write without push");
    chk_trap_quiet: assert property (
        stack_trap_o |-> !mem_valid_o) else $error("trapped access left");
    chk_trap_pulse: assert property (
        stack_trap_o |-> $past(req_i)) else $error("trap without request");
    chk_floor_trap: assert property (
        (pop && sp inside {[16'h0002:16'h0801]}) || (push && sp < STACK_FLOOR)
        |=> stack_trap_o) else $error("missing floor trap");
    chk_sp_indirect: assert property (
        req_i && mode_i == SAG_MODE_INDIRECT && pointer_register_i == SP_INDEX
        |=> stack_trap_o || (ea_o == $past(sp) && $stable(sp)))
        else $error("bad stack pointer indirect");
    chk_guard_quiet: assert property (
        secure_fault_o |-> !mem_valid_o) else $error("guarded access left");
    cov_push: cover property (push ##1 mem_write_o);
    cov_trap: cover property (push ##1 stack_trap_o);
    cov_guard: cover property (secure_fault_o);
endmodule : sag_core_monitor
bind sag_core sag_core_monitor u_monitor (.clk_i, .rst_i, .req_i, .mode_i,
    .pointer_register_i, .ea_o, .mem_valid_o, .mem_write_o,
    .stack_pointer_register_o, .stack_trap_o, .secure_fault_o);

/* verification/sag_data_memory.sv */
// data memory on the far side; stores every write the block sends out
`timescale 1ns/1ps
module sag_data_memory (
    input wire logic clk_i,
    input wire logic mem_valid_i,
    input wire logic mem_write_i,
    input wire logic [15:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic [15:0] peek_addr_i,
    output logic [15:0] peek_data_o
);
    logic [15:0] mem_reg [0:255];
    // word array on address bits 8:1 only, enough for the stack window used
    always_ff @(posedge clk_i) begin
        if (mem_valid_i && mem_write_i) begin
            mem_reg[addr_i[8:1]] <= wdata_i;
        end
    end
    assign peek_data_o = mem_reg[peek_addr_i[8:1]];
endmodule : sag_data_memory

/* verification/test_stack_and_address_generation.sv */
// self-checking bench for the stack and address generation core
`timescale 1ns/1ps
module test_stack_and_address_generation
    import sag_pkg::*;
();
    logic clk_i, rst_i = 1'b1, req_i = 1'b0, wr_en_i = 1'b0;
    logic limit_wr_i = 1'b0, move_instruction_i = 1'b0, byte_op_i = 1'b0;
    logic multiply_instruction_i = 1'b0, step_down_i = 1'b0;
    logic long_literal_i = 1'b0, boot_ram_en_i = 1'b0, seg_ram_en_i = 1'b0;
    logic dest_to_file_i = 1'b0, mem_valid_o, mem_write_o, operand_is_reg_o;
    logic dest_is_file_o, stack_trap_o, secure_fault_o;
    logic [3:0] pointer_register_i = 4'h0, base_operand_register_i = 4'h4;
    logic [3:0] wr_sel_i = 4'h0, dest_reg_o;
    logic [15:0] file_addr_i = 16'hFFFF, lit_offset_i = 16'h0020;
    logic [15:0] wr_data_i = 16'h0000, limit_data_i = 16'h0000;
    logic [15:0] push_data_i = 16'h1234, ea_o, mem_wdata_o, operand_o;
    logic [15:0] base_operand_o, stack_pointer_register_o, peek_data;
    logic [9:0] literal_i = 10'h3FF;
    logic [6:0] pc_hi_i = 7'h7F;
    logic [7:0] status_low_byte_i = 8'hA5;
    sag_mode_type mode_i = SAG_MODE_FILE_DIRECT;
    sag_push_type push_kind_i = SAG_PUSH_DATA;
    sag_seg_type code_seg_i = SAG_SEG_GENERAL;
    int mismatches = 0, checks_done = 0;
    sag_core dut (.clk_i, .rst_i, .req_i, .mode_i, .move_instruction_i,
        .multiply_instruction_i, .byte_op_i, .step_down_i, .pointer_register_i,
        .base_operand_register_i, .file_addr_i, .literal_i, .long_literal_i,
        .lit_offset_i, .wr_en_i, .wr_sel_i, .wr_data_i, .limit_wr_i,
        .limit_data_i, .push_kind_i, .push_data_i, .pc_hi_i, .status_low_byte_i,
        .boot_ram_en_i, .seg_ram_en_i, .code_seg_i, .dest_to_file_i, .ea_o,
        .mem_valid_o, .mem_write_o, .mem_wdata_o, .operand_o, .operand_is_reg_o,
        .base_operand_o, .dest_reg_o, .dest_is_file_o,
        .stack_pointer_register_o, .stack_trap_o, .secure_fault_o);
    sag_data_memory u_mem (.clk_i, .mem_valid_i(mem_valid_o),
        .mem_write_i(mem_write_o), .addr_i(ea_o), .wdata_i(mem_wdata_o),
        .peek_addr_i(16'h0850), .peek_data_o(peek_data));
    // 50 MHz core clock
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    // case inequality, so an unknown never counts as a match
    task automatic chk(input string n, input logic [15:0] e,
            input logic [15:0] g);
        checks_done++;
        if (g !== e) begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", n, e, g);
        end
    endtask : chk
    // one request after an idle edge, so req_i never rises in the time step
    // that lowered it; outputs are registered, so read after the edge
    task automatic op(input sag_mode_type m, input logic [3:0] p);
        @(posedge clk_i);
        #1;
        mode_i = m;
        pointer_register_i = p;
        req_i = 1'b1;
        @(posedge clk_i);
        #1;
        req_i = 1'b0;
    endtask : op
    // register or limit load, then an idle cycle before any stack read
    task automatic put(input logic lim, input logic [3:0] s,
            input logic [15:0] d);
        wr_sel_i = s;
        wr_data_i = d;
        limit_data_i = d;
        wr_en_i = !lim;
        limit_wr_i = lim;
        @(posedge clk_i);
        #1;
        wr_en_i = 1'b0;
        limit_wr_i = 1'b0;
        @(posedge clk_i);
        #1;
    endtask : put
    task automatic t_stack;
        put(1'b1, 4'h0, 16'h0900);
        put(1'b0, SP_INDEX, 16'h0850);
        op(SAG_MODE_STACK_PUSH, SP_INDEX);
        chk("push ea", 16'h0850, ea_o);
        chk("push sp", 16'h0852, stack_pointer_register_o);
        push_kind_i = SAG_PUSH_CALL_PC;
        op(SAG_MODE_STACK_PUSH, SP_INDEX);
        chk("call word", 16'h007F, mem_wdata_o);
        push_kind_i = SAG_PUSH_EXC_PC;
        op(SAG_MODE_STACK_PUSH, SP_INDEX);
        chk("exception word", 16'hA57F, mem_wdata_o);
        push_kind_i = SAG_PUSH_DATA;
        op(SAG_MODE_STACK_POP, SP_INDEX);
        chk("pop ea", 16'h0854, ea_o);
        chk("stored word", 16'h1234, peek_data);
        op(SAG_MODE_INDIRECT, SP_INDEX);
        chk("sp indirect", 16'h0854, ea_o);
        put(1'b0, SP_INDEX, 16'h0800);
        op(SAG_MODE_STACK_POP, SP_INDEX);
        chk("floor trap", 16'h0001, stack_trap_o);
    endtask : t_stack
    task automatic t_limit;
        put(1'b1, 4'h0, 16'h0901);
        put(1'b0, SP_INDEX, 16'h0900);
        op(SAG_MODE_STACK_PUSH, SP_INDEX);
        chk("push at limit", 16'h0001, mem_valid_o);
        op(SAG_MODE_STACK_PUSH, SP_INDEX);
        chk("over limit", 16'h0001, stack_trap_o);
        chk("sp held", 16'h0902, stack_pointer_register_o);
        put(1'b0, SP_INDEX, 16'h0901);
        op(SAG_MODE_STACK_PUSH, SP_INDEX);
        chk("limit bit zero", 16'h0001, stack_trap_o);
    endtask : t_limit
    task automatic t_modes;
        put(1'b0, 4'h3, 16'h1000);
        put(1'b0, 4'h4, 16'h0010);
        op(SAG_MODE_INDIRECT, 4'h3);
        op(SAG_MODE_POST_MOD, 4'h3);
        chk("post ea", 16'h1000, ea_o);
        step_down_i = 1'b1;
        byte_op_i = 1'b1;
        op(SAG_MODE_PRE_MOD, 4'h3);
        chk("pre ea", 16'h1001, ea_o);
        op(SAG_MODE_INDEXED, 4'h3);
        chk("indexed ea", 16'h1011, ea_o);
        op(SAG_MODE_LIT_OFFSET, 4'h3);
        chk("offset ea", 16'h1021, ea_o);
        op(SAG_MODE_FILE_DIRECT, 4'h6);
        chk("near ea", 16'h1FFF, ea_o);
        move_instruction_i = 1'b1;
        op(SAG_MODE_FILE_DIRECT, 4'h6);
        chk("move ea", 16'hFFFF, ea_o);
        move_instruction_i = 1'b0;
    endtask : t_modes
    task automatic t_operands;
        base_operand_register_i = 4'h3;
        op(SAG_MODE_REG_DIRECT, 4'h3);
        chk("register operand", 16'h1001, operand_o);
        chk("register flag", 16'h0001, operand_is_reg_o);
        chk("base operand", 16'h1001, base_operand_o);
        chk("no access", 16'h0000, mem_valid_o);
        base_operand_register_i = 4'h4;
        op(SAG_MODE_LITERAL, 4'h3);
        chk("short literal", 16'h001F, operand_o);
        long_literal_i = 1'b1;
        op(SAG_MODE_LITERAL, 4'h3);
        chk("long literal", 16'h03FF, operand_o);
        long_literal_i = 1'b0;
        multiply_instruction_i = 1'b1;
        op(SAG_MODE_FILE_DIRECT, 4'h6);
        chk("multiply dest", 16'h0006, dest_reg_o);
        chk("register dest", 16'h0000, dest_is_file_o);
        multiply_instruction_i = 1'b0;
        dest_to_file_i = 1'b1;
        op(SAG_MODE_FILE_DIRECT, 4'h6);
        chk("default dest", 16'h0000, dest_reg_o);
        chk("file dest", 16'h0001, dest_is_file_o);
        dest_to_file_i = 1'b0;
    endtask : t_operands
    task automatic t_secure;
        boot_ram_en_i = 1'b1;
        file_addr_i = 16'h0810;
        op(SAG_MODE_FILE_DIRECT, 4'h0);
        chk("boot guard", 16'h0001, secure_fault_o);
        code_seg_i = SAG_SEG_BOOT;
        op(SAG_MODE_FILE_DIRECT, 4'h0);
        chk("boot entry", 16'h0001, mem_valid_o);
        seg_ram_en_i = 1'b1;
        file_addr_i = 16'h0830;
        op(SAG_MODE_FILE_DIRECT, 4'h0);
        chk("segment guard", 16'h0001, secure_fault_o);
        code_seg_i = SAG_SEG_SECURE;
        op(SAG_MODE_FILE_DIRECT, 4'h0);
        chk("segment entry", 16'h0001, mem_valid_o);
    endtask : t_secure
    // prints the counts and the verdict, then ends the run
    task automatic conclude;
        $display("checks %0d, mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : conclude
    // two reset edges, then the scenarios in turn
    initial begin
        repeat (2) @(posedge clk_i);
        #1;
        rst_i = 1'b0;
        t_stack();
        t_limit();
        t_modes();
        t_operands();
        t_secure();
        conclude();
    end
    // the scenarios need about 66 cycles; this cuts a hang short
    initial begin
        #20000;
        mismatches++;
        conclude();
    end
endmodule : test_stack_and_address_generation
